// File: hw/scd_defines.svh
// Function
// - Read returns one 12-bit word chosen by bits 0-4; words 0 to octal 20 only.
// - Test, clear, set and their test forms use descriptor bits 0-7 as a single bit number; only bits 0, 1, 3 and 118 respond.
// - Test returns addressed bit in result bit 0, other eleven bits zero.
// - Clear forces the addressed bit to zero.
// - Test/clear returns the addressed bit, then clears it.
// - Set forces the addressed bit to one.
// - Test/set returns the addressed bit, then sets it.
// - Clear all clears every bit except read-only ones.
// - Test error returns OR of register bits 0 through 39.
// - Memory data parity error sets status bit 0.
// - Storage unit zero address parity error sets status bit 1.
// - Error-correction event sets bit 3, which freezes bits 40-53, 190, 191.
// - Clearing bit 3 unlocks the frozen bits without resetting them.
// - Bit 183 records error type with bit 3: one means double.
// - Control bit 118 inhibits bit 3 for single errors only.
// - Descriptor: function in bits 9-11, address in bits 0-7, bit 8 unused.
// - A descriptor marks the channel full until one result input frees it.
// - Hardware status inputs win over any descriptor clear or set.
`ifndef SCD_DEFINES_SVH
`define SCD_DEFINES_SVH

// ********************************
// Register geometry
// ********************************
`define SCD_NBITS        192
`define SCD_NWORDS       17
`define SCD_LAST_WORD    5'h10
`define SCD_FUNC_MSB     11
`define SCD_FUNC_LSB     9
`define SCD_ADDR_MSB     7
`define SCD_WORD_MSB     4
`define SCD_TE_LAST      39

// ********************************
// Bit positions
// ********************************
`define SCD_BIT_CM_PAR   0
`define SCD_BIT_SU0_PAR  1
`define SCD_BIT_SECDED   3
`define SCD_SYN_LSB      40
`define SCD_SYN_MSB      53
`define SCD_BIT_INHIBIT  118
`define SCD_BIT_ERRTYPE  183
`define SCD_XTRA_LSB     190
`define SCD_XTRA_MSB     191

// ********************************
// Bit categories
// ********************************
`define SCD_MASK_RO   ((192'h3 << 190) | (192'h1 << 183) | (192'h3FFF << 40))
`define SCD_MASK_RW   ((192'h1 << 118) | 192'hB)
`define SCD_MASK_IMPL (`SCD_MASK_RO | `SCD_MASK_RW)
`define SCD_MASK_DS   (192'h1 << 118)
`define SCD_RESET     192'h0

// ********************************
// Bus map
// ********************************
`define SCD_OFF_DESC     4'h0
`define SCD_OFF_RESULT   4'h4
`define SCD_OFF_CHSTAT   4'h8
`define SCD_RESP_OKAY    2'h0
`define SCD_RESP_SLVERR  2'h2
`define SCD_RESP_DECERR  2'h3

`endif

// File: hw/scd_pkg.sv
package scd_pkg;

    typedef enum logic [2:0] {
        SCD_FN_READ  = 3'h0,
        SCD_FN_TEST  = 3'h1,
        SCD_FN_CLR   = 3'h2,
        SCD_FN_TCLR  = 3'h3,
        SCD_FN_SET   = 3'h4,
        SCD_FN_TSET  = 3'h5,
        SCD_FN_CLRA  = 3'h6,
        SCD_FN_TERR  = 3'h7
    } scd_func_t;

    typedef enum logic [1:0] {
        SCD_CH_IDLE = 2'b01,
        SCD_CH_FULL = 2'b10
    } scd_ch_state_t;

endpackage

// File: hw/scd_hw_if.sv
`timescale 1ns/1ps
`default_nettype none
interface scd_hw_if;
    logic         cm_err;
    logic         su0_err;
    logic         sgl_err;
    logic         dbl_err;
    logic [13:0]  syndrome;
    logic [1:0]   extra;
    logic         lock;
    logic         inhibit;
    logic [191:0] set_m;
    logic [191:0] load_m;
    logic [191:0] load_v;
    modport cap  (input cm_err, su0_err, sgl_err, dbl_err, syndrome, extra, lock, inhibit,
                  output set_m, load_m, load_v);
    modport bank (output cm_err, su0_err, sgl_err, dbl_err, syndrome, extra, lock, inhibit,
                  input set_m, load_m, load_v);
endinterface
`default_nettype wire

// File: hw/scd_err_capture.sv
`timescale 1ns/1ps
`default_nettype none
`include "scd_defines.svh"
module scd_err_capture
    import scd_pkg::*;
(
    scd_hw_if.cap hw
);
    logic sec_evt;

    // ********************************
    // Hardware set and load masks
    // ********************************
    always_comb begin
        sec_evt = hw.dbl_err | (hw.sgl_err & ~hw.inhibit);
        hw.set_m = '0;
        hw.set_m[`SCD_BIT_CM_PAR]  = hw.cm_err;
        hw.set_m[`SCD_BIT_SU0_PAR] = hw.su0_err;
        hw.set_m[`SCD_BIT_SECDED]  = sec_evt;
        hw.load_m = '0;
        hw.load_v = '0;
        // Locked bits track the network only while the flag is clear
        if (!hw.lock) begin
            hw.load_m[`SCD_SYN_MSB:`SCD_SYN_LSB]   = '1;
            hw.load_v[`SCD_SYN_MSB:`SCD_SYN_LSB]   = hw.syndrome;
            hw.load_m[`SCD_XTRA_MSB:`SCD_XTRA_LSB] = '1;
            hw.load_v[`SCD_XTRA_MSB:`SCD_XTRA_LSB] = hw.extra;
            hw.load_m[`SCD_BIT_ERRTYPE] = sec_evt;
            hw.load_v[`SCD_BIT_ERRTYPE] = hw.dbl_err;
        end
    end

endmodule // scd_err_capture
`default_nettype wire

// File: hw/scd_chan.sv
`timescale 1ns/1ps
`default_nettype none
`include "scd_defines.svh"
module scd_chan
    import scd_pkg::*;
(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic issue,
    input  wire logic take,
    output logic      full
);
    scd_ch_state_t state_q;

    // ********************************
    // Channel full flag
    // ********************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= SCD_CH_IDLE;
        end else begin
            case (state_q)
                SCD_CH_IDLE: if (issue) state_q <= SCD_CH_FULL;
                SCD_CH_FULL: if (take) state_q <= SCD_CH_IDLE;
                default:     state_q <= SCD_CH_IDLE;
            endcase
        end
    end

    assign full = (state_q == SCD_CH_FULL);

    chk_full_release: assert property (@(posedge aclk) disable iff (!aresetn)
        full && !take |=> full) else $error("channel full dropped without input");

endmodule // scd_chan
`default_nettype wire

// File: hw/scd_top.sv
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "scd_defines.svh"
module scd_top
    import scd_pkg::*;
#(
    parameter int ADDR_W = 4
)(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              cm_parity_err,
    input  wire logic              su0_addr_parity_err,
    input  wire logic              secded_single,
    input  wire logic              secded_double,
    input  wire logic [13:0]       secded_syndrome,
    input  wire logic [1:0]        secded_extra,
    input  wire logic              deadstart,
    output logic [191:0]           scr_bits,
    output logic                   chan_full
);

    // ********************************
    // Elaboration checks
    // ********************************
    if (ADDR_W < 4) begin : g_bad_addr
        $error("ADDR_W must be at least 4");
    end

    logic [191:0] bits_q;
    logic [191:0] bits_d;
    logic [11:0]  result_q;
    logic [11:0]  result_d;
    logic         bvalid_q;
    logic [1:0]   bresp_q;
    logic         rvalid_q;
    logic [31:0]  rdata_q;
    logic [1:0]   rresp_q;
    logic         wr_fire;
    logic         rd_fire;
    logic         op_fire;
    logic         take;
    logic         full;
    logic [11:0]  desc;
    scd_func_t    op_func;
    logic [7:0]   op_addr;
    logic [4:0]   op_word;
    logic [191:0] op_onehot;
    logic         op_ok;
    logic         bit_sel;
    logic [11:0]  word_sel;
    logic [203:0] bits_ext;
    logic         any_err;

    // ********************************
    // Error capture and channel
    // ********************************
    scd_hw_if hw ();

    assign hw.cm_err   = cm_parity_err;
    assign hw.su0_err  = su0_addr_parity_err;
    assign hw.sgl_err  = secded_single;
    assign hw.dbl_err  = secded_double;
    assign hw.syndrome = secded_syndrome;
    assign hw.extra    = secded_extra;
    assign hw.lock     = bits_q[`SCD_BIT_SECDED];
    assign hw.inhibit  = bits_q[`SCD_BIT_INHIBIT];

    scd_err_capture u_cap (
        .hw (hw.cap)
    );

    scd_chan u_chan (
        .aclk    (aclk),
        .aresetn (aresetn),
        .issue   (op_fire),
        .take    (take),
        .full    (full)
    );

    // ********************************
    // Bus handshakes
    // ********************************
    // Address and data are taken together, so no skid storage is needed
    assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
    assign s_axi_wready  = s_axi_awready;
    assign s_axi_arready = ~rvalid_q;
    assign wr_fire       = s_axi_awready;
    assign rd_fire       = s_axi_arvalid & s_axi_arready;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign scr_bits      = bits_q;
    assign chan_full     = full;

    // A blocked descriptor is refused with an error, not queued
    assign op_fire = wr_fire && (s_axi_awaddr[3:0] == `SCD_OFF_DESC)
                     && (&s_axi_wstrb[1:0]) && !full;
    assign take    = rd_fire && (s_axi_araddr[3:0] == `SCD_OFF_RESULT) && full;

    // ********************************
    // Descriptor decode
    // ********************************
    assign desc      = s_axi_wdata[11:0];
    assign op_func   = scd_func_t'(desc[`SCD_FUNC_MSB:`SCD_FUNC_LSB]);
    assign op_addr   = desc[`SCD_ADDR_MSB:0];
    assign op_word   = desc[`SCD_WORD_MSB:0];
    assign op_onehot = 192'h1 << op_addr;
    // Only writable implemented bits accept bit functions
    assign op_ok     = (op_addr < 8'(`SCD_NBITS))
                       && ((op_onehot & `SCD_MASK_RW) != '0);
    assign bit_sel   = op_ok & bits_q[op_addr];
    assign bits_ext  = {12'h000, bits_q};
    assign word_sel  = (op_word <= `SCD_LAST_WORD) ?
                       bits_ext[op_word * 12 +: 12] : 12'h000;
    assign any_err   = |bits_q[`SCD_TE_LAST:0];

    // ********************************
    // Result word
    // ********************************
    always_comb begin
        result_d = 12'h000;
        case (op_func)
            SCD_FN_READ: result_d = word_sel;
            SCD_FN_TEST: result_d = {11'h000, bit_sel};
            SCD_FN_TCLR: result_d = {11'h000, bit_sel};
            SCD_FN_TSET: result_d = {11'h000, bit_sel};
            SCD_FN_TERR: result_d = {11'h000, any_err};
            default:     result_d = 12'h000;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_q <= 12'h000;
        end else if (op_fire) begin
            result_q <= result_d;
        end
    end

    // ********************************
    // Register bits
    // ********************************
    always_comb begin
        bits_d = bits_q;
        if (op_fire) begin
            case (op_func)
                SCD_FN_CLR, SCD_FN_TCLR: if (op_ok) bits_d = bits_d & ~op_onehot;
                SCD_FN_SET, SCD_FN_TSET: if (op_ok) bits_d = bits_d | op_onehot;
                SCD_FN_CLRA: bits_d = bits_d & ~`SCD_MASK_RW;
                default:     bits_d = bits_q;
            endcase
        end
        // Hardware inputs are applied last so they win over any descriptor
        bits_d = (bits_d & ~hw.load_m) | (hw.load_v & hw.load_m);
        bits_d = bits_d | hw.set_m;
        if (deadstart) begin
            bits_d = bits_d & ~`SCD_MASK_DS;
        end
        bits_d = bits_d & `SCD_MASK_IMPL;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bits_q <= `SCD_RESET;
        end else begin
            bits_q <= bits_d;
        end
    end

    // ********************************
    // Write response
    // ********************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `SCD_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            if (op_fire) begin
                bresp_q <= `SCD_RESP_OKAY;
            end else if (s_axi_awaddr[3:0] == `SCD_OFF_DESC ||
                         s_axi_awaddr[3:0] == `SCD_OFF_RESULT ||
                         s_axi_awaddr[3:0] == `SCD_OFF_CHSTAT) begin
                bresp_q <= `SCD_RESP_SLVERR;
            end else begin
                bresp_q <= `SCD_RESP_DECERR;
            end
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ********************************
    // Read response
    // ********************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= `SCD_RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_q <= 1'b1;
            rresp_q  <= `SCD_RESP_OKAY;
            case (s_axi_araddr[3:0])
                `SCD_OFF_RESULT: rdata_q <= {20'h00000, result_q};
                `SCD_OFF_CHSTAT: rdata_q <= {31'h00000000, full};
                `SCD_OFF_DESC:   rdata_q <= 32'h0000_0000;
                default: begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= `SCD_RESP_DECERR;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ********************************
    // Checks
    // ********************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_read_word: assert property (
        op_fire && op_func == SCD_FN_READ |=> result_q == $past(word_sel))
        else $error("read word mismatch");

    chk_bad_word: assert property (
        op_fire && op_func == SCD_FN_READ && op_word > `SCD_LAST_WORD
        |=> result_q == 12'h000)
        else $error("invalid word not zero");

    chk_test_bit: assert property (
        op_fire && op_func == SCD_FN_TEST |=>
        result_q[11:1] == 11'h000 && result_q[0] == $past(bit_sel))
        else $error("test result wrong");

    chk_clear_bit: assert property (
        op_fire && op_func == SCD_FN_CLR && op_ok && !hw.set_m[op_addr]
        && !hw.load_m[op_addr] |=> !bits_q[$past(op_addr)])
        else $error("clear did not clear");

    chk_tclr_bit: assert property (
        op_fire && op_func == SCD_FN_TCLR && op_ok && bits_q[op_addr]
        && !hw.set_m[op_addr] |=> result_q == 12'h001 && !bits_q[$past(op_addr)])
        else $error("test/clear wrong");

    chk_set_bit: assert property (
        op_fire && op_func == SCD_FN_SET && op_ok && !deadstart
        |=> bits_q[$past(op_addr)])
        else $error("set did not set");

    chk_tset_bit: assert property (
        op_fire && op_func == SCD_FN_TSET && op_ok && !bits_q[op_addr] && !deadstart
        |=> result_q == 12'h000 && bits_q[$past(op_addr)])
        else $error("test/set wrong");

    chk_clear_all: assert property (
        op_fire && op_func == SCD_FN_CLRA |=>
        (bits_q & `SCD_MASK_RW & ~$past(hw.set_m)) == '0)
        else $error("clear all left a bit");

    chk_test_error: assert property (
        op_fire && op_func == SCD_FN_TERR |=>
        result_q == {11'h000, |$past(bits_q[`SCD_TE_LAST:0])})
        else $error("test error wrong");

    chk_lock_hold: assert property (
        bits_q[`SCD_BIT_SECDED] |=>
        (bits_q & `SCD_MASK_RO) == $past(bits_q & `SCD_MASK_RO))
        else $error("locked bits moved");

    chk_hw_prio: assert property (
        hw.set_m[`SCD_BIT_CM_PAR] |=> bits_q[`SCD_BIT_CM_PAR])
        else $error("hardware set lost");

    chk_inhibit: assert property (
        secded_single && !secded_double && bits_q[`SCD_BIT_INHIBIT]
        && !bits_q[`SCD_BIT_SECDED]
        && !(op_fire && (op_func == SCD_FN_SET || op_func == SCD_FN_TSET))
        |=> !bits_q[`SCD_BIT_SECDED])
        else $error("single error not inhibited");

    chk_unused_zero: assert property (
        (bits_q & ~`SCD_MASK_IMPL) == '0)
        else $error("unused bit set");

    chk_blocked: assert property (
        full && wr_fire |-> !op_fire)
        else $error("descriptor taken while full");

endmodule // scd_top
`default_nettype wire

// File: test/scd_pp_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Peripheral processor side of the register bus
// ****************************************
module scd_pp_model (
    input  wire logic        aclk,
    output logic [3:0]       s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    output logic [3:0]       s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    initial begin
        s_axi_awaddr = 4'h0;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'h0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 4'h0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
    end

    // Descriptor output: one word, held until taken
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] resp);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
        // Released lines change so nothing can lean on a stale word
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        s_axi_awaddr <= ~a;
        s_axi_wdata <= ~d;
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    // Result input: frees the channel after an output
    task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] resp);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
endmodule // scd_pp_model
`default_nettype wire

// File: test/status_control_descriptor_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "scd_defines.svh"
module status_control_descriptor_unit_tb
    import scd_pkg::*;
();
    logic         aclk = 1'b0;
    logic         aresetn = 1'b0;
    logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic         s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic         cm_parity_err, su0_addr_parity_err, secded_single, secded_double;
    logic         deadstart, chan_full;
    logic [1:0]   s_axi_bresp, s_axi_rresp, secded_extra;
    logic [3:0]   s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [13:0]  secded_syndrome;
    logic [31:0]  s_axi_wdata, s_axi_rdata;
    logic [191:0] scr_bits;
    int           fails = 0, comparisons = 0, cycles = 0;
    localparam logic [7:0] n_inhibit = 8'o166;
    localparam logic [7:0] n_errtype = 8'o267;

    always #5 aclk = ~aclk;

    scd_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .cm_parity_err, .su0_addr_parity_err, .secded_single, .secded_double,
        .secded_syndrome, .secded_extra, .deadstart, .scr_bits, .chan_full);

    scd_pp_model pp (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);

    // ****************************************
    // Checks and closing
    // ****************************************
    task automatic chk(input logic [191:0] seen, input logic [191:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %0t %s", $time, what);
        end
    endtask

    task automatic test_done();
        if (fails == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Whole run needs a few hundred cycles; the ceiling leaves wide margin
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            test_done();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // Output then exactly one input; bit 8 is set to show it is ignored
    task automatic op(input scd_func_t f, input logic [7:0] a, input logic [11:0] exp,
                      input string what);
        logic [1:0]  r;
        logic [31:0] d;
        pp.wr(`SCD_OFF_DESC, {20'h0, f, 1'b1, a}, 4'hF, r);
        chk({r, chan_full}, 3'h1, "desc accepted");
        pp.rd(`SCD_OFF_RESULT, d, r);
        chk({r, d}, {2'h0, 20'h0, exp}, what);
        chk(chan_full, 1'b0, "channel freed");
    endtask

    task automatic pulse_err(input logic dbl);
        @(posedge aclk);
        secded_single <= !dbl;
        secded_double <= dbl;
        @(posedge aclk);
        secded_single <= 1'b0;
        secded_double <= 1'b0;
        tick(2);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        logic [1:0]  r;
        logic [31:0] d;
        chk(chan_full, 1'b0, "reset full");
        chk(scr_bits, 192'h0, "reset state");
        pp.rd(`SCD_OFF_CHSTAT, d, r);
        chk({r, d}, 34'h0, "channel idle");
    endtask

    task automatic t_funcs();
        op(SCD_FN_SET, 8'h00, 12'h000, "set 0");
        op(SCD_FN_TEST, 8'h00, 12'h001, "test 0");
        op(SCD_FN_TERR, 8'h00, 12'h001, "test error");
        op(SCD_FN_TSET, 8'h01, 12'h000, "tset 1");
        op(SCD_FN_SET, 8'h03, 12'h000, "set 3");
        op(SCD_FN_SET, n_inhibit, 12'h000, "set 118");
        op(SCD_FN_SET, 8'h02, 12'h000, "set unused");
        op(SCD_FN_SET, 8'o50, 12'h000, "set ro 40");
        op(SCD_FN_READ, 8'h00, 12'h00B, "word 0");
        op(SCD_FN_READ, 8'hE9, 12'h400, "word 9");
        op(SCD_FN_READ, 8'h03, 12'h000, "word 3");
        op(SCD_FN_READ, 8'h11, 12'h000, "word 21 octal");
        op(SCD_FN_TCLR, 8'h00, 12'h001, "tclr 0");
        op(SCD_FN_TEST, 8'h00, 12'h000, "0 cleared");
        op(SCD_FN_CLR, 8'h01, 12'h000, "clr 1");
        op(SCD_FN_READ, 8'h00, 12'h008, "word 0 after");
        op(SCD_FN_CLRA, 8'h00, 12'h000, "clear all");
        chk(scr_bits, 192'h0, "all cleared");
        op(SCD_FN_TERR, 8'h00, 12'h000, "no error");
    endtask

    task automatic t_secded();
        @(posedge aclk);
        secded_syndrome <= 14'h2A5C;
        secded_extra <= 2'h2;
        pulse_err(1'b0);
        @(posedge aclk);
        secded_syndrome <= 14'h1234;
        secded_extra <= 2'h1;
        tick(3);
        chk(scr_bits, (192'h2 << 190) | (192'h2A5C << 40) | 192'h8, "frozen");
        op(SCD_FN_CLR, 8'h03, 12'h000, "clr 3");
        tick(2);
        chk(scr_bits[53:40], 14'h1234, "unlocked");
        op(SCD_FN_SET, n_inhibit, 12'h000, "inhibit");
        pulse_err(1'b0);
        chk(scr_bits[3], 1'b0, "single inhibited");
        pulse_err(1'b1);
        chk({scr_bits[183], scr_bits[3]}, 2'h3, "double");
        op(SCD_FN_TEST, n_errtype, 12'h000, "test ro");
        op(SCD_FN_READ, 8'h0F, 12'h408, "word 15");
        op(SCD_FN_CLRA, 8'h00, 12'h000, "clear all");
        chk({scr_bits[183], scr_bits[118], scr_bits[3]}, 3'h4, "ro kept");
    endtask

    task automatic t_hw();
        @(posedge aclk);
        cm_parity_err <= 1'b1;
        su0_addr_parity_err <= 1'b1;
        op(SCD_FN_TCLR, 8'h00, 12'h001, "tclr held");
        chk(scr_bits[1:0], 2'h3, "hw wins");
        @(posedge aclk);
        cm_parity_err <= 1'b0;
        su0_addr_parity_err <= 1'b0;
        op(SCD_FN_CLRA, 8'h00, 12'h000, "clear all");
        op(SCD_FN_SET, n_inhibit, 12'h000, "set 118");
        @(posedge aclk);
        deadstart <= 1'b1;
        @(posedge aclk);
        deadstart <= 1'b0;
        tick(2);
        chk(scr_bits[118], 1'b0, "deadstart");
    endtask

    task automatic t_refuse();
        logic [1:0]  r;
        logic [31:0] d;
        pp.wr(`SCD_OFF_DESC, {20'h0, SCD_FN_SET, 9'h000}, 4'hF, r);
        chk({r, chan_full}, 3'h1, "first out");
        pp.wr(`SCD_OFF_DESC, {20'h0, SCD_FN_SET, 9'h001}, 4'hF, r);
        chk(r, `SCD_RESP_SLVERR, "second out");
        pp.rd(`SCD_OFF_CHSTAT, d, r);
        chk({r, d}, 34'h1, "chstat full");
        pp.rd(`SCD_OFF_RESULT, d, r);
        chk({chan_full, scr_bits[1:0]}, 3'h1, "one op only");
        pp.wr(`SCD_OFF_DESC, {20'h0, SCD_FN_SET, 9'h001}, 4'h1, r);
        chk({r, chan_full}, {`SCD_RESP_SLVERR, 1'b0}, "strobe");
        pp.wr(`SCD_OFF_RESULT, 32'h0, 4'hF, r);
        chk(r, `SCD_RESP_SLVERR, "ro offset");
        pp.rd(4'hC, d, r);
        chk({r, d}, {`SCD_RESP_DECERR, 32'h0}, "unmapped");
        op(SCD_FN_CLRA, 8'h00, 12'h000, "clear all");
        chk(scr_bits, (192'h1 << 190) | (192'h1 << 183) | (192'h1234 << 40), "ro left");
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        cm_parity_err = 1'b0;
        su0_addr_parity_err = 1'b0;
        secded_single = 1'b0;
        secded_double = 1'b0;
        secded_syndrome = 14'h0;
        secded_extra = 2'h0;
        deadstart = 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_funcs();
        t_secded();
        t_hw();
        t_refuse();
        test_done();
    end
endmodule // status_control_descriptor_unit_tb
`default_nettype wire
